// File: design/psm_mapper.sv
// Purpose: Program space address mapper with register slave
// Assumes: Avalon-MM master per published protocol, synchronous inputs
// Notes: One-cycle registered mapping output
//
// Functional notes
// R1 - Program words 24 bits, data words 16
// R2 - Table page above EA gives address
// R3 - Table page top bit selects configuration
// R4 - Visibility joins page with EA low bits
// R5 - Each visibility page is 32K words
// R6 - Visibility never reaches configuration memory
// R7 - Visibility is read-only, low word only
// R8 - Table ops reach every program byte
// R9 - Program bit 15 from page bit 0
// R10 - Control bit 2 enables visibility, resets 0
// R11 - Control bit 3 flags level above 7
// R12 - Priority level is msb over status bits
// R13 - Otherwise plain data-memory access
`timescale 1ns/1ps
module psm_mapper (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Avalon-MM slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [1:0] avs_response,
	// Core side
	input wire logic [15:0] cpu_status_reg,
	input wire logic prio_msb_set,
	input wire psm_pkg::psm_req_t req,
	// Mapped access and priority level
	output psm_pkg::psm_map_t map_r,
	output logic vis_write_err_r,
	output logic [3:0] cpu_priority_level
);

	// ****************************************
	// Registers
	// ****************************************
	logic [15:0] core_control_r;
	logic [15:0] core_control_nxt;
	logic [7:0] table_page_reg_r;
	logic [7:0] table_page_reg_nxt;
	logic [7:0] visibility_page_reg_r;
	logic [7:0] visibility_page_reg_nxt;
	logic ack_r;
	logic [31:0] rdata_r;
	logic [1:0] resp_r;
	psm_pkg::psm_map_t map_nxt;

	// ****************************************
	// Bus decode
	// ****************************************
	wire logic access = (avs_read || avs_write) && !ack_r;
	wire logic hit_cc = avs_address == psm_pkg::OFF_CORE_CONTROL;
	wire logic hit_tp = avs_address == psm_pkg::OFF_TABLE_PAGE;
	wire logic hit_vp = avs_address == psm_pkg::OFF_VIS_PAGE;
	wire logic hit_st = avs_address == psm_pkg::OFF_STATUS;
	wire logic mapped = hit_cc || hit_tp || hit_vp || hit_st;
	// Write lands at the edge where the master sees waitrequest low
	wire logic wr_lo = avs_write && ack_r && avs_byteenable[0];
	wire logic wr_cc = wr_lo && hit_cc;
	wire logic wr_tp = wr_lo && hit_tp;
	wire logic wr_vp = wr_lo && hit_vp;

	wire logic vis_en = core_control_r[psm_pkg::CC_VIS_EN_BIT];
	wire logic prio_msb = core_control_r[psm_pkg::CC_PRIO_MSB_BIT];
	// Clear-only: writing 0 clears, a set from the core in the same cycle wins
	wire logic clr_msb = wr_cc && !avs_writedata[psm_pkg::CC_PRIO_MSB_BIT]; // see R11

	// ****************************************
	// Address formation
	// ****************************************
	psm_addr_gen i_psm_addr_gen (
		.req(req),
		.table_page(table_page_reg_r),
		.vis_page(visibility_page_reg_r),
		.vis_en(vis_en),
		.map(map_nxt)
	);

	// ****************************************
	// Next-state logic
	// ****************************************
	always_comb begin
		core_control_nxt = core_control_r;
		if (wr_cc) begin
			core_control_nxt[psm_pkg::CC_VIS_EN_BIT] = avs_writedata[psm_pkg::CC_VIS_EN_BIT]; // see R10
		end
		if (prio_msb_set) begin
			core_control_nxt[psm_pkg::CC_PRIO_MSB_BIT] = 1'b1; // see R11
		end else if (clr_msb) begin
			core_control_nxt[psm_pkg::CC_PRIO_MSB_BIT] = 1'b0; // see R11
		end
	end

	assign table_page_reg_nxt = wr_tp ? avs_writedata[7:0] : table_page_reg_r; // see R2
	assign visibility_page_reg_nxt = wr_vp ? avs_writedata[7:0] : visibility_page_reg_r; // see R5

	// Priority level: msb above status bits 7..5
	assign cpu_priority_level = {prio_msb, cpu_status_reg[psm_pkg::SR_PRIO_HI:psm_pkg::SR_PRIO_LO]}; // see R12

	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit_cc) begin
			rd_mux = {16'h0000, core_control_r};
		end else if (hit_tp) begin
			rd_mux = {24'h00_0000, table_page_reg_r};
		end else if (hit_vp) begin
			rd_mux = {24'h00_0000, visibility_page_reg_r};
		end else if (hit_st) begin
			// Live level and whether it exceeds the threshold
			rd_mux = {27'h000_0000, cpu_priority_level > psm_pkg::PRIO_LIMIT, cpu_priority_level}; // see R11
		end
	end

	// ****************************************
	// State
	// ****************************************
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			core_control_r <= psm_pkg::CORE_CONTROL_RST; // see R10
			table_page_reg_r <= psm_pkg::TABLE_PAGE_RST;
			visibility_page_reg_r <= psm_pkg::VIS_PAGE_RST;
		end else begin
			core_control_r <= core_control_nxt;
			table_page_reg_r <= table_page_reg_nxt;
			visibility_page_reg_r <= visibility_page_reg_nxt;
		end
	end

	// One wait cycle, then acknowledge; unmapped answers with slave error
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ack_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			resp_r <= 2'b00;
		end else begin
			ack_r <= access;
			rdata_r <= (access && avs_read) ? rd_mux : 32'h0000_0000;
			resp_r <= (access && !mapped) ? 2'b10 : 2'b00;
		end
	end

	assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
	assign avs_readdata = rdata_r;
	assign avs_response = resp_r;

	// Mapped access registered so 24-bit program address leaves a flop
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			map_r <= '0;
			vis_write_err_r <= 1'b0;
		end else begin
			map_r <= map_nxt; // see R1 see R4 see R13
			// Writes through the visibility window are dropped and flagged
			vis_write_err_r <= req.valid && req.write && map_nxt.kind == psm_pkg::PSM_KIND_VIS; // see R7
		end
	end

endmodule // psm_mapper

// File: include/psm_pkg.sv
// Purpose: Shared constants and carriers for the program space address mapper
// Assumes: Avalon-MM slave, 32-bit data, word-aligned byte addresses
// Notes: All offsets and field positions live here
package psm_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [3:0] OFF_CORE_CONTROL = 4'h0;
	localparam logic [3:0] OFF_TABLE_PAGE = 4'h4;
	localparam logic [3:0] OFF_VIS_PAGE = 4'h8;
	localparam logic [3:0] OFF_STATUS = 4'hC;

	// ****************************************
	// Fields
	// ****************************************
	localparam int CC_PRIO_MSB_BIT = 3;
	localparam int CC_VIS_EN_BIT = 2;
	localparam int SR_PRIO_HI = 7;
	localparam int SR_PRIO_LO = 5;
	localparam int TBL_CFG_BIT = 7;
	localparam int EA_TOP_BIT = 15;
	localparam logic [3:0] PRIO_LIMIT = 4'h7;

	localparam logic [15:0] CORE_CONTROL_RST = 16'h0000;
	localparam logic [7:0] TABLE_PAGE_RST = 8'h00;
	localparam logic [7:0] VIS_PAGE_RST = 8'h00;

	// ****************************************
	// Carriers
	// ****************************************
	typedef enum logic [1:0] {
		PSM_KIND_DATA,
		PSM_KIND_TABLE,
		PSM_KIND_VIS
	} psm_kind_t;

	typedef struct packed {
		logic valid;
		logic table_op;
		logic write;
		logic [15:0] ea;
	} psm_req_t;

	typedef struct packed {
		logic valid;
		psm_kind_t kind;
		logic prog;
		logic cfg;
		logic write;
		logic word_only;
		logic [23:0] prog_addr;
		logic [15:0] data_addr;
	} psm_map_t;

endpackage

// File: design/psm_addr_gen.sv
// Purpose: Combinational program address formation
// Assumes: Page values come from registers in the top module
// Notes: Pure logic, no state
`timescale 1ns/1ps
module psm_addr_gen (
	// Request
	input wire psm_pkg::psm_req_t req,
	// Page and mode state
	input wire logic [7:0] table_page,
	input wire logic [7:0] vis_page,
	input wire logic vis_en,
	// Result
	output psm_pkg::psm_map_t map
);

	wire logic ea_top = req.ea[psm_pkg::EA_TOP_BIT];
	wire logic vis_hit = !req.table_op && vis_en && ea_top; // see R4 see R13
	wire logic [23:0] table_addr = {table_page, req.ea}; // see R2 see R8
	// Top address bit forced low, EA bit 15 replaced by page bit 0
	wire logic [23:0] vis_addr = {1'b0, vis_page, req.ea[14:0]}; // see R6 see R9 see R5

	always_comb begin
		map = '0;
		map.valid = req.valid;
		map.data_addr = req.ea;
		map.kind = psm_pkg::PSM_KIND_DATA; // see R13
		if (req.table_op) begin
			map.kind = psm_pkg::PSM_KIND_TABLE;
			map.prog = 1'b1;
			map.prog_addr = table_addr;
			map.cfg = table_page[psm_pkg::TBL_CFG_BIT]; // see R3
			map.write = req.write;
		end else if (vis_hit) begin
			map.kind = psm_pkg::PSM_KIND_VIS;
			map.prog = 1'b1;
			map.prog_addr = vis_addr;
			map.word_only = 1'b1; // see R7
			map.write = 1'b0; // see R7
		end else begin
			map.write = req.write;
		end
	end

endmodule // psm_addr_gen

// File: verification/psm_mapper_checker.sv
// Purpose: Port assertions for the mapper
// Assumes: Bound from tb_top
// Notes: Watches design inputs and outputs
`timescale 1ns/1ps
module psm_mapper_checker (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Watched ports
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic [15:0] cpu_status_reg,
	input wire logic prio_msb_set,
	input wire psm_pkg::psm_req_t req,
	input wire psm_pkg::psm_map_t map_r,
	input wire logic vis_write_err_r,
	input wire logic [3:0] cpu_priority_level
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	a_one_wait: assert property ((avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus wait too long");
	a_table_addr: assert property (req.valid && req.table_op |=> map_r.prog_addr[15:0] == $past(req.ea))
		else $error("table address");
	a_cfg_route: assert property (map_r.kind == psm_pkg::PSM_KIND_TABLE |-> map_r.cfg == map_r.prog_addr[23])
		else $error("table route");
	a_vis_low: assert property (map_r.kind == psm_pkg::PSM_KIND_VIS |-> map_r.prog_addr[14:0] == $past(req.ea[14:0]))
		else $error("window address");
	a_vis_ro: assert property (map_r.kind == psm_pkg::PSM_KIND_VIS |-> !map_r.write && map_r.word_only && !map_r.cfg && !map_r.prog_addr[23])
		else $error("window access");
	a_vis_err: assert property (map_r.valid && map_r.kind == psm_pkg::PSM_KIND_VIS && $past(req.write) |-> vis_write_err_r)
		else $error("window write");
	a_prio_set: assert property (prio_msb_set |=> cpu_priority_level[3])
		else $error("priority msb not set");
	a_data_plain: assert property (req.valid && !req.table_op && !req.ea[15] |=> !map_r.prog)
		else $error("data remapped");
	a_prio_join: assert property (cpu_priority_level[2:0] == cpu_status_reg[7:5])
		else $error("priority level");
endmodule // psm_mapper_checker

// File: verification/psm_core_model.sv
// Purpose: Load/store side of the core
// Assumes: One request per call
// Notes: Drops valid right after capture
`timescale 1ns/1ps
module psm_core_model (
	// Clock
	input wire logic clk,
	// Request
	output psm_pkg::psm_req_t req
);
	initial req = '0;
	task automatic issue(input logic t, input logic w, input logic [15:0] ea);
		@(posedge clk);
		req <= '{1'b1, t, w, ea};
		@(posedge clk);
		req.valid <= 1'b0;
		#1;
	endtask
endmodule // psm_core_model

// File: verification/tb_top.sv
// Purpose: Self-checking bench for the mapper
// Assumes: One wait state per bus access
// Notes: Map results read 1 ns after capture
`timescale 1ns/1ps
module tb_top;
	logic clk = 0, nrst = 0, avs_read = 0, avs_write = 0, prio_msb_set = 0, vis_write_err_r, avs_waitrequest;
	logic [3:0] avs_address = '0, avs_byteenable = 4'hF, cpu_priority_level;
	logic [31:0] avs_writedata = '0, avs_readdata, q;
	logic [1:0] avs_response, r;
	logic [15:0] cpu_status_reg = '0;
	psm_pkg::psm_req_t req;
	psm_pkg::psm_map_t map_r;
	int n_errors = 0, checks = 0;
	always #50 clk = ~clk;
	psm_core_model i_psm_core_model (.clk(clk), .req(req));
	psm_mapper i_psm_mapper (
		.clk(clk),
		.nrst(nrst),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.avs_response(avs_response),
		.cpu_status_reg(cpu_status_reg),
		.prio_msb_set(prio_msb_set),
		.req(req),
		.map_r(map_r),
		.vis_write_err_r(vis_write_err_r),
		.cpu_priority_level(cpu_priority_level)
	);
	task automatic conclude();
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		logic ws;
		ws = 1'b1;
		@(posedge clk);
		avs_address <= a;
		avs_read <= !w;
		avs_write <= w;
		avs_writedata <= d;
		for (int i = 0; i < 20 && ws; i++) begin
			@(posedge clk);
			ws = avs_waitrequest;
			q = avs_readdata;
			r = avs_response;
		end
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (ws) begin
			n_errors++;
			$display("CHECK FAILED %0t bus timeout", $time);
			conclude();
		end
	endtask
	task automatic mp(input logic t, input logic w, input logic [15:0] ea, input psm_pkg::psm_kind_t k,
		input logic c, input logic [23:0] a);
		i_psm_core_model.issue(t, w, ea);
		chk({map_r.valid, map_r.prog, map_r.kind, map_r.cfg, map_r.prog_addr},
			{1'b1, k != psm_pkg::PSM_KIND_DATA, k, c, a});
	endtask
	initial begin
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		bus(0, 4'h0, 0); chk(q, 0);
		chk(r, 2'b00);
		bus(0, 4'h2, 0); chk(r, 2'b10);
		$display("test reset done");
		bus(1, 4'h4, 32'h85);
		mp(1, 0, 16'h1234, psm_pkg::PSM_KIND_TABLE, 1, 24'h85_1234);
		bus(1, 4'h4, 32'h05);
		mp(1, 1, 16'hFFFF, psm_pkg::PSM_KIND_TABLE, 0, 24'h05_FFFF);
		chk(map_r.write, 1'b1);
		avs_byteenable <= 4'h0;
		bus(1, 4'h4, 32'hFF);
		avs_byteenable <= 4'hF;
		bus(0, 4'h4, 0); chk(q, 32'h05);
		$display("test table done");
		bus(1, 4'h0, 32'h4); bus(0, 4'h0, 0); chk(q, 32'h4);
		bus(1, 4'h8, 32'hA5);
		mp(0, 0, 16'hF00F, psm_pkg::PSM_KIND_VIS, 0, 24'h52_F00F);
		mp(0, 1, 16'h8001, psm_pkg::PSM_KIND_VIS, 0, 24'h52_8001);
		chk({map_r.write, map_r.word_only, vis_write_err_r}, 3'b011);
		mp(1, 0, 16'h8001, psm_pkg::PSM_KIND_TABLE, 0, 24'h05_8001);
		mp(0, 0, 16'h700F, psm_pkg::PSM_KIND_DATA, 0, 0);
		$display("test window done");
		bus(1, 4'h0, 0);
		mp(0, 0, 16'hF00F, psm_pkg::PSM_KIND_DATA, 0, 0); chk(map_r.data_addr, 16'hF00F);
		$display("test hidden done");
		@(posedge clk);
		cpu_status_reg <= 16'h00E0;
		prio_msb_set <= 1'b1;
		@(posedge clk);
		prio_msb_set <= 1'b0;
		bus(0, 4'h0, 0); chk(q, 32'h8);
		chk(cpu_priority_level, 4'hF);
		bus(1, 4'hC, 32'h0); chk(r, 2'b00);
		bus(0, 4'hC, 0); chk(q, 32'h1F);
		bus(1, 4'h0, 32'h8); bus(0, 4'h0, 0); chk(q, 32'h8);
		bus(1, 4'h0, 0); bus(0, 4'h0, 0); chk(q, 0);
		$display("test priority done");
		conclude();
	end
endmodule // tb_top
bind psm_mapper psm_mapper_checker i_psm_mapper_checker (.clk(clk), .nrst(nrst), .avs_read(avs_read),
	.avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .cpu_status_reg(cpu_status_reg),
	.prio_msb_set(prio_msb_set), .req(req),
	.map_r(map_r), .vis_write_err_r(vis_write_err_r), .cpu_priority_level(cpu_priority_level));
